// ### dmasc_ctrl.v
// Function
// - Finish unit, release bus on external request
// - Short address mode ignores NMI
// - Full mode runs only with both enables
// - Full mode NMI clears master enable
// - Resume when master enable set again
// - Clearing enable stops after current unit
// - Reset and standby initialise; sleep continues
// - Four end interrupt lines, fixed priority
// - End irq when enable low, irq enable high
// - Full mode masks B end irq
// - Registers unreachable during controller bus cycle; ready raised at the edge that starts one still lets an access finish in it
// - Long address access as four bytes; here MAR is read and written as one word at a word address
// - Halted channel drops activating requests
// - Block mode NMI halts, drops request
// - Block resume waits, finishes remaining block
// - Block counter keeps partial value
// - 24-bit address, 1-Mbyte mode masks top
// - Dead cycle leaves address, counter alone
//
// Our own choices: the APB register port and the placing of the registers.
`include "dmasc_defs.vh"
module dmasc_ctrl #(
    parameter NCH = 4,
    parameter AW = 24
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire i_nmi,
    input wire i_standby,
    input wire i_ext_bus_request,
    input wire i_refresh_req,
    input wire [NCH-1:0] i_xfer_req,
    input wire i_bus_grant,
    output reg o_bus_req,
    output reg o_xfer_strobe,
    output reg [1:0] o_xfer_chan,
    output reg [AW-1:0] o_xfer_addr,
    output reg [NCH-1:0] o_req_consumed,
    output reg o_end_irq_ch0a,
    output reg o_end_irq_ch0b,
    output reg o_end_irq_ch1a,
    output reg o_end_irq_ch1b
);

// ------------------------------------------------------------
// Synchronisers for pins
// ------------------------------------------------------------
reg [2:0] pin_s1_reg;
reg [2:0] pin_s2_reg;
reg [NCH-1:0] req_s1_reg;
reg [NCH-1:0] req_s2_reg;
reg nmi_d_reg;
wire bus_want_pin = i_ext_bus_request | i_refresh_req;
wire nmi_rise = pin_s2_reg[0] & ~nmi_d_reg;
wire stby = pin_s2_reg[1];
wire ext_want = pin_s2_reg[2];

// Control pins: bus wanted elsewhere, standby, nmi
always @(posedge i_ref_clk)
begin
    if (i_rst)
    begin
        pin_s1_reg <= 3'h0;
        pin_s2_reg <= 3'h0;
    end
    else
    begin
        pin_s1_reg <= {bus_want_pin, i_standby, i_nmi};
        pin_s2_reg <= pin_s1_reg;
    end
end

// Activation requests, one per channel half
always @(posedge i_ref_clk)
begin
    if (i_rst)
    begin
        req_s1_reg <= {NCH{1'b0}};
        req_s2_reg <= {NCH{1'b0}};
    end
    else
    begin
        req_s1_reg <= i_xfer_req;
        req_s2_reg <= req_s1_reg;
    end
end

// Edge detector starts low, the idle level of the pin
always @(posedge i_ref_clk)
begin
    if (i_rst)
    begin
        nmi_d_reg <= 1'b0;
    end
    else
    begin
        nmi_d_reg <= pin_s2_reg[0];
    end
end

// ------------------------------------------------------------
// Channel state
// ------------------------------------------------------------
reg [4:0] ctrl_reg [0:NCH-1];
reg [AW-1:0] mar_reg [0:NCH-1];
reg [7:0] blk_reg [0:NCH-1];
reg [NCH-1:0] pend_reg;
reg [1:0] gctrl_reg;
reg [1:0] state_reg;
reg [1:0] cur_reg;
wire full0 = gctrl_reg[`DMASC_B_FULL];

localparam ST_IDLE = 2'h0;
localparam ST_REQ = 2'h1;
localparam ST_XFER = 2'h2;

// Channel may run: full mode idles B and needs master enable on A
wire [NCH-1:0] run;
genvar g;
generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_run
        wire full_b = full0 & (g % 2 == 1);
        // In full mode the A half carries both enables
        assign run[g] = ~full_b & ctrl_reg[g][`DMASC_B_XFER_EN] &
            (~full0 | ctrl_reg[g][`DMASC_B_MASTER_EN]);
    end
endgenerate

// Fixed priority 0A, 0B, 1A, 1B
wire [NCH-1:0] ready_ch = pend_reg & run;
reg [1:0] pick;
always @*
begin
    pick = 2'h0;
    if (ready_ch[0])
        pick = 2'h0;
    else if (ready_ch[1])
        pick = 2'h1;
    else if (ready_ch[2])
        pick = 2'h2;
    else
        pick = 2'h3;
end

// ------------------------------------------------------------
// Register access decode
// ------------------------------------------------------------
wire bus_cycle = (state_reg == ST_XFER);
wire mapped = (i_paddr <= `DMASC_OFS_STAT) & (i_paddr[1:0] == 2'h0);

// Writes land at the edge that completes the access, the one after the edge that raises ready,
// and ready is never raised at the edge that ends a controller bus cycle
wire apb_wr = i_psel & i_penable & i_pwrite & o_pready & mapped;
wire apb_rd_ok = i_psel & i_penable & ~bus_cycle;
wire [3:0] widx = i_paddr[5:2];

// Word units advance the address by two
wire [AW-1:0] addr_step = ctrl_reg[cur_reg][`DMASC_B_WORD] ?
    {{(AW-2){1'b0}}, 2'h2} : {{(AW-1){1'b0}}, 1'b1};
wire nmi_hit = nmi_rise & full0;

// ------------------------------------------------------------
// Transfer sequencer and register writes
// ------------------------------------------------------------
integer k;
always @(posedge i_ref_clk)
begin
    if (i_rst | stby)
    begin
        for (k = 0; k < NCH; k = k + 1)
        begin
            ctrl_reg[k] <= `DMASC_RST_CTRL;
            mar_reg[k] <= {AW{1'b0}};
            blk_reg[k] <= `DMASC_BLK_INIT;
        end
        pend_reg <= {NCH{1'b0}};
        gctrl_reg <= 2'h0;
        state_reg <= ST_IDLE;
        cur_reg <= 2'h0;
        o_bus_req <= 1'b0;
        o_xfer_strobe <= 1'b0;
        o_xfer_chan <= 2'h0;
        o_xfer_addr <= {AW{1'b0}};
        o_req_consumed <= {NCH{1'b0}};
    end
    else
    begin
        o_xfer_strobe <= 1'b0;
        o_req_consumed <= {NCH{1'b0}};
        for (k = 0; k < NCH; k = k + 1)
        begin
            if (req_s2_reg[k] & ~pend_reg[k])
            begin
                o_req_consumed[k] <= 1'b1;
                // Request dropped while halted, never kept
                pend_reg[k] <= run[k];
            end
        end
        if (nmi_hit)
        begin
            ctrl_reg[0][`DMASC_B_MASTER_EN] <= 1'b0;
            ctrl_reg[2][`DMASC_B_MASTER_EN] <= 1'b0;
            for (k = 0; k < NCH; k = k + 1)
                if (ctrl_reg[k][`DMASC_B_BLOCK])
                    pend_reg[k] <= 1'b0;
        end
        case (state_reg)
            ST_IDLE:
            begin
                if (|ready_ch & ~ext_want)
                begin
                    o_bus_req <= 1'b1;
                    state_reg <= ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (~|ready_ch)
                begin
                    // Dead request: nothing moves
                    o_bus_req <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                else if (i_bus_grant)
                begin
                    cur_reg <= pick;
                    state_reg <= ST_XFER;
                end
            end
            ST_XFER:
            begin
                // One unit per grant; a halt only takes effect between units
                o_xfer_strobe <= 1'b1;
                o_xfer_chan <= cur_reg;
                o_xfer_addr <= gctrl_reg[`DMASC_B_MB1] ?
                    (mar_reg[cur_reg] & `DMASC_MAR_1MB) : mar_reg[cur_reg];
                mar_reg[cur_reg] <= mar_reg[cur_reg] + addr_step;
                if (ctrl_reg[cur_reg][`DMASC_B_BLOCK] & (blk_reg[cur_reg] != 8'h01))
                    blk_reg[cur_reg] <= blk_reg[cur_reg] - 8'h01;
                else
                begin
                    blk_reg[cur_reg] <= `DMASC_BLK_INIT;
                    pend_reg[cur_reg] <= 1'b0;
                end
                o_bus_req <= 1'b0;
                state_reg <= ST_IDLE;
            end
            default:
                state_reg <= ST_IDLE;
        endcase
        if (apb_wr)
        begin
            for (k = 0; k < NCH; k = k + 1)
            begin
                if (widx == k)
                    ctrl_reg[k] <= i_pwdata[4:0];
                if (widx == k + 4)
                    mar_reg[k] <= i_pwdata[AW-1:0];
                if (widx == k + 8)
                    blk_reg[k] <= i_pwdata[7:0];
            end
            if (i_paddr == `DMASC_OFS_GCTRL)
                gctrl_reg <= i_pwdata[1:0];
        end
    end
end

// ------------------------------------------------------------
// End interrupt conditions
// ------------------------------------------------------------
wire [NCH-1:0] irq_raw;
generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_irq
        assign irq_raw[g] = ~ctrl_reg[g][`DMASC_B_XFER_EN] &
            ctrl_reg[g][`DMASC_B_IRQ_EN] & ~(full0 & (g % 2 == 1));
    end
endgenerate

// ------------------------------------------------------------
// Register read mux
// ------------------------------------------------------------
reg [31:0] rd_mux;
always @*
begin
    rd_mux = 32'h0;
    case (widx)
        4'h0, 4'h1, 4'h2, 4'h3:
        begin
            rd_mux = {27'h0, ctrl_reg[widx[1:0]]};
        end
        4'h4, 4'h5, 4'h6, 4'h7:
        begin
            rd_mux = {8'h0, mar_reg[widx[1:0]]};
        end
        4'h8, 4'h9, 4'ha, 4'hb:
        begin
            rd_mux = {24'h0, blk_reg[widx[1:0]]};
        end
        4'hc:
        begin
            rd_mux = {30'h0, gctrl_reg};
        end
        4'hd:
        begin
            // Status is read only: sequencer state and pending flags
            rd_mux = {26'h0, state_reg, pend_reg};
        end
        default:
        begin
            rd_mux = 32'h0;
        end
    endcase
end

// ------------------------------------------------------------
// APB answer
// ------------------------------------------------------------
wire ack_next = apb_rd_ok & ~o_pready;

always @(posedge i_ref_clk)
begin
    if (i_rst)
    begin
        o_prdata <= 32'h0;
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
    end
    else if (i_psel & ~i_penable)
    begin
        // Setup cycle never answers
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
        o_prdata <= 32'h0;
    end
    else
    begin
        // Ready pulses one cycle; it is always low in the cycle after a bus cycle
        o_pready <= ack_next;
        o_pslverr <= ack_next & ~mapped;
        o_prdata <= (ack_next & ~i_pwrite & mapped) ? rd_mux : 32'h0;
    end
end

// ------------------------------------------------------------
// End interrupt lines
// ------------------------------------------------------------
// Levels follow the control bits one cycle late
always @(posedge i_ref_clk)
begin
    if (i_rst)
    begin
        o_end_irq_ch0a <= 1'b0;
        o_end_irq_ch0b <= 1'b0;
        o_end_irq_ch1a <= 1'b0;
        o_end_irq_ch1b <= 1'b0;
    end
    else
    begin
        o_end_irq_ch0a <= irq_raw[0];
        o_end_irq_ch0b <= irq_raw[1];
        o_end_irq_ch1a <= irq_raw[2];
        o_end_irq_ch1b <= irq_raw[3];
    end
end

endmodule

// ### dmasc_defs.vh
`ifndef DMASC_DEFS_VH
`define DMASC_DEFS_VH
// ------------------------------------------------------------
// Register map (byte addresses, one word each)
// ------------------------------------------------------------
`define DMASC_OFS_CTRL0A 12'h000
`define DMASC_OFS_CTRL0B 12'h004
`define DMASC_OFS_CTRL1A 12'h008
`define DMASC_OFS_CTRL1B 12'h00c
`define DMASC_OFS_MAR0A 12'h010
`define DMASC_OFS_MAR0B 12'h014
`define DMASC_OFS_MAR1A 12'h018
`define DMASC_OFS_MAR1B 12'h01c
`define DMASC_OFS_CNT0A 12'h020
`define DMASC_OFS_CNT0B 12'h024
`define DMASC_OFS_CNT1A 12'h028
`define DMASC_OFS_CNT1B 12'h02c
`define DMASC_OFS_GCTRL 12'h030
`define DMASC_OFS_STAT 12'h034
// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define DMASC_B_XFER_EN 0
`define DMASC_B_MASTER_EN 1
`define DMASC_B_IRQ_EN 2
`define DMASC_B_BLOCK 3
`define DMASC_B_WORD 4
`define DMASC_B_FULL 0
`define DMASC_B_MB1 1
`define DMASC_RST_CTRL 5'h00
`define DMASC_BLK_INIT 8'h04
`define DMASC_MAR_1MB 24'h0fffff
`endif

// ### dmasc_ctrl_monitor.sv
module dmasc_ctrl_monitor (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire i_standby,
    input wire i_ext_bus_request,
    input wire i_refresh_req,
    input wire i_bus_grant,
    input wire o_bus_req,
    input wire o_xfer_strobe,
    input wire o_end_irq_ch0a,
    input wire o_end_irq_ch0b,
    input wire o_end_irq_ch1b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic full_reg;
    logic [4:0] c0a_reg;
    wire wr_done = i_psel && i_penable && o_pready && i_pwrite;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // Shadow of software settings
    // ------------------------------------------------------------
    // Cleared early on standby so the shadow never claims more than the design
    always @(posedge i_ref_clk)
    begin
        if (i_rst || i_standby)
        begin
            full_reg <= 1'b0;
            c0a_reg <= 5'h00;
        end
        else if (wr_done && i_paddr == 12'h030)
            full_reg <= i_pwdata[0];
        else if (wr_done && i_paddr == 12'h000)
            c0a_reg <= i_pwdata[4:0];
    end
    a_strobe_granted: assert property (o_xfer_strobe |-> $past(i_bus_grant))
        else $error("unit moved without bus grant");
    a_one_unit: assert property (o_xfer_strobe |=> !o_xfer_strobe)
        else $error("bus kept past one unit");
    a_yield_bus: assert property ($rose(o_bus_req) |->
        !$past(i_ext_bus_request) && !$past(i_refresh_req))
        else $error("bus requested while wanted elsewhere");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error answer without ready");
    a_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_bus_req && !o_xfer_strobe)
        else $error("activity after reset");
    a_standby_halt: assert property (i_standby [*4] |=> !o_xfer_strobe)
        else $error("transfer during standby");
    a_full_b_quiet: assert property (full_reg && $past(full_reg, 2) |->
        !o_end_irq_ch0b && !o_end_irq_ch1b)
        else $error("b half end irq in full mode");
    a_irq_follows: assert property (c0a_reg == $past(c0a_reg, 6) |->
        o_end_irq_ch0a == (c0a_reg[2] && !c0a_reg[0]))
        else $error("end irq level wrong");
endmodule

bind dmasc_ctrl dmasc_ctrl_monitor u_dmasc_ctrl_monitor (.*);

// ### dmasc_bus_model.sv
module dmasc_bus_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_bus_req,
    input wire logic [3:0] i_lat,
    output logic o_bus_grant
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_reg;
    // ------------------------------------------------------------
    // Bus arbiter of the cpu side
    // ------------------------------------------------------------
    // Grant withdrawn at once on release, so a late strobe is caught
    always @(posedge i_ref_clk)
    begin
        if (i_rst || !i_bus_req)
        begin
            wait_reg <= 4'h0;
            o_bus_grant <= 1'b0;
        end
        else if (wait_reg >= i_lat)
            o_bus_grant <= 1'b1;
        else
            wait_reg <= wait_reg + 4'h1;
    end
endmodule

// ### dmasc_ctrl_tb_top.sv
`include "dmasc_defs.vh"
module dmasc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic rd = 1'b0, wr = 1'b1;
    localparam logic [31:0] zero = 32'h0;
    localparam logic [7:0] tbl [4] = '{8'h43, 8'he1, 8'hb0, 8'h02};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, nmi = 1'b0, stby = 1'b0;
    logic ext = 1'b0, refr = 1'b0, grant, pready, perr, ext_bus_request, stb;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'ha430, prdata;
    logic [3:0] xreq = 4'h0, lat = 4'h0, used, irq;
    logic [1:0] chan;
    logic [23:0] addr;
    logic [64:0] e;
    logic [64:0] exp_q[$];
    logic [25:0] sq[$];
    int err_total = 0, cmp_count = 0, cyc = 0;
    always #25 clk = ~clk;
    dmasc_ctrl u_dmasc_ctrl (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(perr), .i_nmi(nmi), .i_standby(stby), .i_ext_bus_request(ext),
        .i_refresh_req(refr), .i_xfer_req(xreq), .i_bus_grant(grant), .o_bus_req(ext_bus_request),
        .o_xfer_strobe(stb), .o_xfer_chan(chan), .o_xfer_addr(addr), .o_req_consumed(used),
        .o_end_irq_ch0a(irq[0]), .o_end_irq_ch0b(irq[1]), .o_end_irq_ch1a(irq[2]),
        .o_end_irq_ch1b(irq[3]));
    dmasc_bus_model u_dmasc_bus_model (.i_ref_clk(clk), .i_rst(rst), .i_bus_req(ext_bus_request),
        .i_lat(lat), .o_bus_grant(grant));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task results();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Drivers; answers are queued and judged by the watcher
    // ------------------------------------------------------------
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic x);
        exp_q.push_back({x, m, d});
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (!pready);
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask
    task xfer(input int ch, input logic [23:0] a, input logic go);
        int n;
        n = 0;
        if (go)
            sq.push_back({ch[1:0], a});
        xreq[ch] <= 1'b1;
        do
            @(posedge clk);
        while (!used[ch] && ++n < 100);
        xreq[ch] <= 1'b0;
        n = 0;
        do
            @(posedge clk);
        while ((ext_bus_request || sq.size() != 0 || n < 20) && ++n < 200);
    endtask
    task nmi_hit(input logic [11:0] a, input logic [31:0] x);
        nmi <= 1'b1;
        repeat (4) @(posedge clk);
        nmi <= 1'b0;
        repeat (4) @(posedge clk);
        apb(rd, a, x, 32'h1f, 1'b0);
    endtask
    always @(posedge clk)
    begin
        if (++cyc == 20000)
        begin
            err_total++;
            results();
        end
        if (psel && pen && pready)
        begin
            e = exp_q.pop_front();
            chk({31'h0, perr}, {31'h0, e[64]});
            chk(prdata & e[63:32], e[31:0] & e[63:32]);
        end
        if (stb)
            chk({6'h0, chan, addr}, sq.size() != 0 ? {6'h0, sq.pop_front()} : 32'hffffffff);
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(rd, `DMASC_OFS_CTRL0A, zero, 32'h1f, 1'b0);
        apb(rd, `DMASC_OFS_CNT0A, 32'h4, 32'hff, 1'b0);
        apb(wr, 12'h040, 32'h1f, zero, 1'b1);
        apb(rd, `DMASC_OFS_CTRL0A, zero, 32'h1f, 1'b0);
        $display("test reset done");
        for (int k = 0; k < 2; k++)
        begin
            seed = xs(seed);
            lat <= seed[3:0];
            apb(wr, `DMASC_OFS_GCTRL, {30'h0, k[0], 1'b0}, zero, 1'b0);
            apb(wr, `DMASC_OFS_MAR0B, seed, zero, 1'b0);
            apb(rd, `DMASC_OFS_MAR0B, seed, k ? 32'hfffff : 32'hffffff, 1'b0);
            apb(wr, `DMASC_OFS_CTRL0B, 32'h1, zero, 1'b0);
            fork
                xfer(1, seed[23:0] & (k ? `DMASC_MAR_1MB : 24'hffffff), 1'b1);
                begin
                    {refr, ext} <= k ? 2'b10 : 2'b01;
                    repeat (15) @(posedge clk);
                    chk({31'h0, ext_bus_request}, zero);
                    {refr, ext} <= 2'b00;
                end
            join
        end
        apb(wr, `DMASC_OFS_CTRL0B, 32'h4, zero, 1'b0);
        $display("test bus release done");
        foreach (tbl[i])
        begin
            apb(wr, `DMASC_OFS_GCTRL, {31'h0, tbl[i][7]}, zero, 1'b0);
            apb(wr, `DMASC_OFS_CTRL0A, {29'h0, tbl[i][6:4]}, zero, 1'b0);
            @(posedge clk);
            chk({28'h0, irq}, {28'h0, tbl[i][3:0]});
        end
        apb(wr, `DMASC_OFS_CTRL0B, zero, zero, 1'b0);
        $display("test end irq done");
        apb(wr, `DMASC_OFS_GCTRL, 32'h1, zero, 1'b0);
        apb(wr, `DMASC_OFS_MAR0A, seed, zero, 1'b0);
        apb(wr, `DMASC_OFS_CTRL0A, 32'h3, zero, 1'b0);
        nmi_hit(`DMASC_OFS_CTRL0A, 32'h1);
        xfer(0, 24'h0, 1'b0);
        apb(wr, `DMASC_OFS_CTRL0A, 32'h3, zero, 1'b0);
        repeat (20) @(posedge clk);
        xfer(0, seed[23:0], 1'b1);
        $display("test full mode nmi done");
        apb(wr, `DMASC_OFS_GCTRL, zero, zero, 1'b0);
        apb(wr, `DMASC_OFS_CTRL0A, zero, zero, 1'b0);
        apb(wr, `DMASC_OFS_MAR1A, seed, zero, 1'b0);
        apb(wr, `DMASC_OFS_CTRL1A, 32'h1, zero, 1'b0);
        nmi_hit(`DMASC_OFS_CTRL1A, 32'h1);
        xfer(2, seed[23:0], 1'b1);
        apb(wr, `DMASC_OFS_MAR1A, seed & 32'hfffffe, zero, 1'b0);
        apb(wr, `DMASC_OFS_CTRL1A, 32'h11, zero, 1'b0);
        xfer(2, seed[23:0] & 24'hfffffe, 1'b1);
        xfer(2, (seed[23:0] & 24'hfffffe) + 24'h2, 1'b1);
        apb(wr, `DMASC_OFS_MAR0A, seed, zero, 1'b0);
        apb(wr, `DMASC_OFS_CTRL0A, 32'h9, zero, 1'b0);
        for (int u = 0; u < 3; u++)
            sq.push_back({2'h0, seed[23:0] + 24'(u)});
        xfer(0, seed[23:0] + 24'h3, 1'b1);
        apb(rd, `DMASC_OFS_CNT0A, 32'h4, 32'hff, 1'b0);
        apb(wr, `DMASC_OFS_CTRL0A, zero, zero, 1'b0);
        $display("test word and block done");
        stby <= 1'b1;
        repeat (6) @(posedge clk);
        stby <= 1'b0;
        repeat (4) @(posedge clk);
        apb(rd, `DMASC_OFS_CTRL1A, zero, 32'h1f, 1'b0);
        $display("test short mode and standby done");
        results();
    end
endmodule
